// >>> pkg/cfg_front_map.svh
/*
  Offsets, field positions, masks and reset values of the front of the
  configuration header for function 0. Assumes nothing of its surroundings.
*/
`ifndef CFG_FRONT_MAP_SVH
`define CFG_FRONT_MAP_SVH

`define OFS_IDENT_WORD        6'h00
`define OFS_CONTROL_WORD      6'h01
`define BIT_IO_ON             0
`define BIT_MEM_ON            1
`define BIT_INITIATOR         2
`define BIT_SPECIAL           3
`define BIT_WRITE_INVALIDATE  4
`define BIT_PALETTE_SNOOP     5
`define BIT_PARITY_RESPONSE   6
`define BIT_SYSTEM_ERROR      8
`define BIT_INTX_OFF          10
`define CONTROL_WRITABLE_MASK 16'h0567
`define CONTROL_RESET_VALUE   16'h0000

`endif

// >>> pkg/cfg_front_pkg.sv
/*
  Types shared by the configuration front block and its control store.
  Assumes the map header is available on the include path.
*/
package cfg_front_pkg;
  typedef logic [15:0] half_word_t;
  typedef enum logic {
    access_idle,
    access_busy
  } access_state_t;
endpackage

// >>> pkg/control_store_if.sv
/*
  Interface between the configuration front and its control store.
  Assumes a single clock domain.
*/
`timescale 1ns/1ps
interface control_store_if;
  logic                     write_strobe;
  logic [3:0]               byte_lane;
  logic [31:0]              write_data;
  cfg_front_pkg::half_word_t control;
  modport front (output write_strobe, output byte_lane, output write_data, input control);
  modport store (input write_strobe, input byte_lane, input write_data, output control);
endinterface

// >>> design/control_store.sv
/*
  The writable command word of one function. Holds only the writable bits;
  the rest read as zero. Assumes synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "cfg_front_map.svh"
module control_store (
  input  wire logic    clk,
  input  wire logic    rst,
  control_store_if.store port_a
);
  cfg_front_pkg::half_word_t word;
  cfg_front_pkg::half_word_t next_word;

  always_comb begin
    next_word = word;
    if (port_a.byte_lane[0]) begin
      next_word[7:0] = port_a.write_data[7:0];
    end
    if (port_a.byte_lane[1]) begin
      next_word[15:8] = port_a.write_data[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      word <= `CONTROL_RESET_VALUE;
    end else if (port_a.write_strobe) begin
      // Masking on the way in keeps reserved and hardwired bits at zero.
      word <= next_word & `CONTROL_WRITABLE_MASK;
    end
  end

  assign port_a.control = word;
endmodule

// >>> design/cfg_front.sv
/*
  Front of the configuration header for function 0: maker and part codes
  and the command word, reached by configuration cycles on a dword index
  with byte enables. Assumes the bus interface decodes configuration cycles
  and hands over one request per pulse; the second function supplies its own
  copies of the two error enables.
*/
// How it works
// - Dword 0 low half returns fixed maker code; writes ignored.
// - Dword 0 high half returns fixed part code; writes ignored.
// - Command bits 15 to 11 always read zero.
// - Command bit 10 set blocks this function's interrupt line.
// - Command bit 9 reads zero; no fast back-to-back transactions.
// - Command bit 8 enables the system error driver.
// - Address parity error reported only when both enables are on: bit 8 or its other-function copy, and bit 6 or its copy.
// - Command bit 7 always reads zero.
// - Bit 6 enables parity error response on both error lines.
// - Bit 5 set makes palette writes snooped, not claimed.
// - Bit 4 hardwired zero; only plain memory writes are used.
// - Bit 3 hardwired zero; special cycles never answered.
// - Initiator requests pass only while bit 2 is set.
// - Memory cycles claimed only while bit 1 set; resets clear.
// - I/O cycles claimed only while bit 0 set; resets clear.
// - This function keeps its own command word.
// - Error enables ORed with the other function's copies.
`timescale 1ns/1ps
`include "cfg_front_map.svh"
module cfg_front #(
  parameter logic [15:0] MAKER_CODE = 16'h1234, // Arbitrary value.
  parameter logic [15:0] PART_CODE  = 16'h5678  // Arbitrary value.
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cfg_request,
  input  wire logic        cfg_write,
  input  wire logic [5:0]  cfg_index,
  input  wire logic [3:0]  cfg_byte_enable,
  input  wire logic [31:0] cfg_write_data,
  output logic [31:0]      cfg_read_data,
  output logic             cfg_done,
  input  wire logic        other_system_error_on,
  input  wire logic        other_parity_response_on,
  output logic             system_error_driver_on,
  output logic             parity_response_on,
  input  wire logic        intx_request,
  output logic             intx_assert,
  input  wire logic        memory_hit,
  output logic             memory_claim,
  input  wire logic        io_hit,
  output logic             io_claim,
  input  wire logic        palette_write_hit,
  output logic             palette_snoop,
  input  wire logic        special_cycle_hit,
  output logic             special_cycle_claim,
  input  wire logic        initiator_request,
  output logic             initiator_go,
  output logic             write_invalidate_allow,
  output logic             fast_b2b_allow,
  input  wire logic        address_parity_error,
  input  wire logic        data_parity_error,
  output logic             system_error_assert,
  output logic             parity_error_assert
);
  control_store_if store_link ();
  cfg_front_pkg::half_word_t    control;
  cfg_front_pkg::access_state_t state;
  logic                         hit_control;

  function automatic logic index_is(input logic [5:0] idx, input logic [5:0] want);
    return idx == want;
  endfunction

  control_store u_control_store (
    .clk    (clk),
    .rst    (rst),
    .port_a (store_link)
  );

  assign control                 = store_link.control;
  assign hit_control             = index_is(cfg_index, `OFS_CONTROL_WORD);
  assign store_link.write_strobe = cfg_request && cfg_write && hit_control && state == cfg_front_pkg::access_idle;
  // The status half of dword 1 lives elsewhere; only lanes 0 and 1 reach here.
  assign store_link.byte_lane    = {2'h0, cfg_byte_enable[1:0]};
  assign store_link.write_data   = cfg_write_data;

  // Each request is answered one cycle later; a request during the answer waits.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= cfg_front_pkg::access_idle;
    end else begin
      unique case (state)
        cfg_front_pkg::access_idle: begin
          if (cfg_request) begin
            state <= cfg_front_pkg::access_busy;
          end
        end
        cfg_front_pkg::access_busy: begin
          state <= cfg_front_pkg::access_idle;
        end
      endcase
    end
  end

  assign cfg_done = state == cfg_front_pkg::access_busy;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_read_data <= 32'h0000_0000;
    end else if (cfg_request && !cfg_write && state == cfg_front_pkg::access_idle) begin
      if (index_is(cfg_index, `OFS_IDENT_WORD)) begin
        cfg_read_data <= {PART_CODE, MAKER_CODE};
      end else if (hit_control) begin
        cfg_read_data <= {16'h0000, control};
      end else begin
        cfg_read_data <= 32'h0000_0000;
      end
    end
  end

  always_comb begin
    // Other function's copies widen behaviour but never show in this readback.
    system_error_driver_on = control[`BIT_SYSTEM_ERROR] | other_system_error_on;
    parity_response_on     = control[`BIT_PARITY_RESPONSE] | other_parity_response_on;
    intx_assert            = intx_request && !control[`BIT_INTX_OFF];
    // Snoop is worked out first because the two claims below read it in this same pass.
    palette_snoop          = palette_write_hit && control[`BIT_PALETTE_SNOOP];
    memory_claim           = memory_hit && control[`BIT_MEM_ON] && !palette_snoop;
    io_claim               = io_hit && control[`BIT_IO_ON] && !palette_snoop;
    special_cycle_claim    = 1'b0 & special_cycle_hit;
    initiator_go           = initiator_request && control[`BIT_INITIATOR];
    write_invalidate_allow = control[`BIT_WRITE_INVALIDATE];
    fast_b2b_allow         = 1'b0;
    system_error_assert    = address_parity_error && system_error_driver_on && parity_response_on;
    parity_error_assert    = data_parity_error && parity_response_on;
  end
endmodule

// >>> bench/cfg_front_properties.sv
/* Port checker for cfg_front. Assumes one clock with synchronous reset. */
`timescale 1ns/1ps
module cfg_front_checks #(
  parameter logic [15:0] MAKER_CODE = 16'h1234,
  parameter logic [15:0] PART_CODE  = 16'h5678
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cfg_request,
  input wire logic        cfg_write,
  input wire logic        cfg_done,
  input wire logic        memory_hit,
  input wire logic        memory_claim,
  input wire logic        io_hit,
  input wire logic        io_claim,
  input wire logic [5:0]  cfg_index,
  input wire logic [3:0]  cfg_byte_enable,
  input wire logic [31:0] cfg_write_data,
  input wire logic [31:0] cfg_read_data,
  input wire logic        palette_snoop,
  input wire logic        system_error_driver_on,
  input wire logic        parity_response_on,
  input wire logic        other_system_error_on,
  input wire logic        other_parity_response_on,
  input wire logic        address_parity_error,
  input wire logic        data_parity_error,
  input wire logic        system_error_assert,
  input wire logic        parity_error_assert
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire take = cfg_request && !cfg_done;
  property p_answer; take |=> cfg_done ##1 !cfg_done; endproperty
  a_answer: assert property (p_answer) else $error("answer pulse wrong");
  property p_ident; take && !cfg_write && cfg_index == 6'h00 |=> cfg_read_data == {PART_CODE, MAKER_CODE}; endproperty
  a_ident: assert property (p_ident) else $error("ident wrong");
  property p_fixed; take && !cfg_write && cfg_index == 6'h01 |=> (cfg_read_data[15:0] & 16'hFA98) == 16'h0000; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits set");
  property p_serr; system_error_assert == (address_parity_error && system_error_driver_on && parity_response_on); endproperty
  a_serr: assert property (p_serr) else $error("serr wrong");
  property p_perr; parity_error_assert == (data_parity_error && parity_response_on); endproperty
  a_perr: assert property (p_perr) else $error("perr wrong");
  property p_or; (other_system_error_on |-> system_error_driver_on) and (other_parity_response_on |-> parity_response_on); endproperty
  a_or: assert property (p_or) else $error("enable or wrong");
  property p_mem; take && cfg_write && cfg_index == 6'h01 && cfg_byte_enable[0] && cfg_write_data[5:0] == 6'h03
    |=> ##1 memory_claim == memory_hit && io_claim == io_hit; endproperty
  a_mem: assert property (p_mem) else $error("decode gate wrong");
  property p_rst; $fell(rst) |-> !memory_claim && !io_claim && !palette_snoop; endproperty
  a_rst: assert property (p_rst) else $error("not cleared");
  c_write: cover property (take && cfg_write);
  c_serr: cover property (system_error_assert);
  c_snoop: cover property (palette_snoop);
endmodule
bind cfg_front cfg_front_checks #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)) u_cfg_front_checks (.*);

// >>> bench/cfg_host_model.sv
/* Host issuing configuration cycles. Assumes an answer within 8 cycles. */
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic        clk,
  input  wire logic        cfg_done,
  input  wire logic [31:0] cfg_read_data,
  output logic             cfg_request = 1'b0,
  output logic             cfg_write = 1'b0,
  output logic [5:0]       cfg_index = 6'h00,
  output logic [3:0]       cfg_byte_enable = 4'h0,
  output logic [31:0]      cfg_write_data = 32'h00000000
);
  task automatic xfer(input logic w, input logic [5:0] i, input logic [3:0] b, input logic [31:0] d,
                      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    {cfg_request, cfg_write, cfg_index, cfg_byte_enable, cfg_write_data} <= {1'b1, w, i, b, d};
    do begin
      @(posedge clk);
      n = n + 1;
    end while (cfg_done !== 1'b1 && n < 8);
    r = cfg_read_data;
    // Released data is inverted so a stale value is never taken for a live one.
    {cfg_request, cfg_write_data} <= {1'b0, ~d};
  endtask
endmodule

// >>> bench/cfg_front_bench.sv
/* Self-checking bench for cfg_front. Assumes the host model and bound checker. */
`timescale 1ns/1ps
module cfg_front_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_request, cfg_write, cfg_done, system_error_driver_on, parity_response_on, intx_assert;
  logic        memory_claim, io_claim, palette_snoop, special_cycle_claim, initiator_go, write_invalidate_allow;
  logic        fast_b2b_allow, system_error_assert, parity_error_assert;
  logic [5:0]  cfg_index;
  logic [3:0]  cfg_byte_enable, b;
  logic [31:0] cfg_write_data, cfg_read_data, rd, d;
  logic [9:0]  ins = 10'h000;
  logic [15:0] cmd = 16'h0000;
  integer      seed = 47, num_errors = 0, total_checks = 0, cycles = 0, i;
  wire other_system_error_on = ins[9], other_parity_response_on = ins[8], palette_write_hit = ins[7],
       intx_request = ins[6], memory_hit = ins[5], io_hit = ins[4], special_cycle_hit = ins[3],
       initiator_request = ins[2], address_parity_error = ins[1], data_parity_error = ins[0];
  initial forever #5 clk = ~clk;
  cfg_host_model u_cfg_host_model (.*);
  // Identity codes are arbitrary; non-default values catch hard-wired codes.
  cfg_front #(.MAKER_CODE(16'hA5C3), .PART_CODE(16'h3C5A)) u_cfg_front (.*);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic finish_test;
    if (num_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [11:0] gates(logic [15:0] c, logic [9:0] x);
    logic s, p, v;
    s = c[8] | x[9];
    p = c[6] | x[8];
    v = x[7] & c[5];
    return {s, p, x[6] & !c[10], x[5] & c[1] & !v, x[4] & c[0] & !v, v, 1'b0, x[2] & c[2], 2'b00, x[1] & s & p, x[0] & p};
  endfunction
  always @(posedge clk) begin
    ins <= 10'($random(seed));
    cycles <= cycles + 1;
    if (cycles > 5000) begin
      num_errors++;
      finish_test;
    end
  end
  logic [11:0] gw;
  wire  [11:0] gs = {system_error_driver_on, parity_response_on, intx_assert, memory_claim, io_claim, palette_snoop,
                     special_cycle_claim, initiator_go, write_invalidate_allow, fast_b2b_allow, system_error_assert,
                     parity_error_assert};
  // Sampled on the falling edge so the combinational gates have settled after the inputs moved.
  always @(negedge clk) begin
    if (!rst && !cfg_request) begin
      gw = gates(cmd, ins);
      check("error enables", 32'(gs[11:10]), 32'(gw[11:10]));
      check("interrupt", 32'(gs[9]), 32'(gw[9]));
      check("space claims", 32'(gs[8:7]), 32'(gw[8:7]));
      check("palette snoop", 32'(gs[6]), 32'(gw[6]));
      check("special cycle", 32'(gs[5]), 32'(gw[5]));
      check("initiator", 32'(gs[4]), 32'(gw[4]));
      check("fixed enables", 32'(gs[3:2]), 32'(gw[3:2]));
      check("error reports", 32'(gs[1:0]), 32'(gw[1:0]));
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    u_cfg_host_model.xfer(1'b1, 6'h00, 4'hF, 32'hFFFFFFFF, rd);
    u_cfg_host_model.xfer(1'b0, 6'h00, 4'hF, 32'h0, rd);
    check("ident", rd, 32'h3C5AA5C3);
    for (i = 0; i < 60; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : (i == 2) ? 32'h00000003 : $random(seed);
      b = (i < 3) ? 4'h3 : 4'($random(seed));
      u_cfg_host_model.xfer(1'b1, 6'h01, b, d, rd);
      cmd = {b[1] ? d[15:8] : cmd[15:8], b[0] ? d[7:0] : cmd[7:0]} & 16'h0567;
      u_cfg_host_model.xfer(1'b0, 6'h01, 4'hF, 32'h0, rd);
      check("command", 32'(rd[15:0]), 32'(cmd));
      repeat (i % 4) @(posedge clk);
    end
    u_cfg_host_model.xfer(1'b0, 6'h2A, 4'hF, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    @(posedge clk);
    rst <= 1'b1;
    cmd = 16'h0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    u_cfg_host_model.xfer(1'b0, 6'h01, 4'hF, 32'h0, rd);
    check("reset command", 32'(rd[15:0]), 32'h0);
    finish_test;
  end
endmodule
